// ===== rtl/hfr_top.sv
// Transmit FIFO flags, receive clock pin and low receive data port.
`timescale 1ns/10ps
`include "hfr_cfg.svh"
module hfr_top #(
   parameter int PTR_W = `HFR_PTR_W
) (
   // Reference clock and full-chip reset.
   input wire logic core_clk,
   input wire logic nrst,
   // Host transmit clock and its controls.
   input wire logic tx_host_clock,
   input wire logic tx_write_req,
   input wire logic tx_fifo_reset_req,
   // Configuration and select pins.
   input wire logic chip_select_n,
   input wire logic fifo_bypass_sel,
   input wire logic flag_polarity_select,
   input wire logic codec_bypass_sel,
   input wire logic tx_selftest_enable,
   // Encoder side on the reference clock.
   input wire logic enc_char_take,
   input wire logic enc_tx_ready,
   input wire logic enc_char_tick,
   // Transmit flag pins.
   output logic tx_fifo_half_flag,
   output logic tx_fifo_half_flag_oe,
   output logic tx_fifo_empty_flag,
   output logic tx_fifo_empty_flag_oe,
   // Receive character stream on the reference clock.
   input wire logic rx_char_strobe,
   input wire logic rx_char_is_cmd,
   input wire logic [7:0] rx_decoded_low,
   input wire logic [7:0] rx_raw_low,
   // Receive clock pin.
   input wire logic rx_host_clock_in,
   output logic rx_host_clock_out,
   output logic rx_host_clock_oe,
   // Receive data pins.
   input wire logic rx_output_enable,
   output logic [7:0] rx_parallel_word,
   output logic rx_parallel_word_oe
);
   logic [PTR_W-1:0] wr_gray;
   logic link_rst;
   logic [PTR_W-1:0] wr_gray_s;
   logic link_rst_s;
   logic [`HFR_SYNC_W-1:0] pins_s;
   logic cs_n_s;
   logic fifo_on_s;
   logic pol_s;
   logic dec_on_s;
   logic bist_s;
   logic rx_host_clock_s;
   logic rx_output_enable_s;

   hfr_txlink #(.PTR_W(PTR_W)) u_txlink (
      .tx_host_clock(tx_host_clock),
      .nrst(nrst),
      .chip_select_n(chip_select_n),
      .tx_write_req(tx_write_req),
      .tx_fifo_reset_req(tx_fifo_reset_req),
      .fifo_bypass_sel(fifo_bypass_sel),
      .wr_ptr_gray(wr_gray),
      .fifo_reset_active(link_rst)
   );

   // Gray pointer and reset level cross into the reference clock domain.
   hfr_sync #(.W(PTR_W + 1)) u_ptr_sync (
      .clk(core_clk),
      .nrst(nrst),
      .d({link_rst, wr_gray}),
      .q({link_rst_s, wr_gray_s})
   );

   hfr_sync #(.W(`HFR_SYNC_W)) u_pin_sync (
      .clk(core_clk),
      .nrst(nrst),
      .d({chip_select_n, fifo_bypass_sel, flag_polarity_select, codec_bypass_sel,
          !tx_selftest_enable, !rx_host_clock_in, rx_output_enable}),
      .q(pins_s)
   );

   always_comb begin
      cs_n_s = pins_s[6];
      fifo_on_s = pins_s[5];
      pol_s = pins_s[4];
      dec_on_s = pins_s[3];
      bist_s = pins_s[2];
      // The receive clock pin idles high, so it crosses inverted and reads high out of reset.
      rx_host_clock_s = !pins_s[1];
      rx_output_enable_s = pins_s[0];
   end

   // Transmit FIFO occupancy and reset sequencing.
   hfr_pkg::hfr_fifo_state_t st_reg;
   hfr_pkg::hfr_fifo_state_t st_next;
   logic [PTR_W-1:0] rd_reg;
   logic [PTR_W-1:0] rd_next;
   logic [PTR_W-1:0] wr_bin;
   logic [PTR_W-1:0] occ;
   logic take;

   always_comb begin
      wr_bin = '0;
      wr_bin[PTR_W - 1] = wr_gray_s[PTR_W - 1];
      for (int i = PTR_W - 2; i >= 0; i--) begin
         wr_bin[i] = wr_gray_s[i] ^ wr_bin[i + 1];
      end
      occ = wr_bin - rd_reg;
      // Reads toward the encoder are suspended while self-test runs.
      take = enc_char_take && fifo_on_s && !bist_s && (occ != '0) && (st_reg == hfr_pkg::HFR_RUN);
      st_next = st_reg;
      rd_next = take ? rd_reg + {{(PTR_W-1){1'b0}}, 1'b1} : rd_reg;
      case (st_reg)
         hfr_pkg::HFR_RUN: begin
            if (link_rst_s && fifo_on_s) begin
               st_next = hfr_pkg::HFR_FLUSH;
            end
         end
         hfr_pkg::HFR_FLUSH: begin
            rd_next = '0;
            if (!link_rst_s) begin
               st_next = hfr_pkg::HFR_SETTLE;
            end
         end
         hfr_pkg::HFR_SETTLE: begin
            // One more cycle lets the zeroed write pointer settle after the crossing.
            rd_next = '0;
            st_next = hfr_pkg::HFR_RUN;
         end
         default: begin
            st_next = hfr_pkg::HFR_RUN;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_reg <= hfr_pkg::HFR_RUN;
         rd_reg <= '0;
      end else begin
         st_reg <= st_next;
         rd_reg <= rd_next;
      end
   end

   // Self-test sequence position for the loop marker.
   logic [8:0] seq_reg;
   logic [8:0] seq_next;
   logic loop_mark;

   always_comb begin
      seq_next = seq_reg;
      loop_mark = 1'b0;
      if (!bist_s) begin
         seq_next = 9'h000;
      end else if (enc_char_tick) begin
         if (seq_reg == `HFR_SEQ_LEN - 9'h001) begin
            seq_next = 9'h000;
            loop_mark = 1'b1;
         end else begin
            seq_next = seq_reg + 9'h001;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         seq_reg <= 9'h000;
      end else begin
         seq_reg <= seq_next;
      end
   end

   // Transmit flag pins, all registered on the reference clock.
   logic half_next;
   logic half_oe_next;
   logic empty_raw;
   logic empty_next;
   logic empty_oe_next;
   logic resetting;

   always_comb begin
      resetting = (st_reg != hfr_pkg::HFR_RUN) || (link_rst_s && fifo_on_s);
      half_next = 1'b0;
      if (fifo_on_s) begin
         if (resetting) begin
            half_next = 1'b1;
         end else begin
            half_next = !cs_n_s && (occ >= `HFR_HALF_LEVEL);
         end
      end
      half_oe_next = 1'b1;
      if (bist_s) begin
         empty_raw = loop_mark;
      end else if (!fifo_on_s) begin
         empty_raw = enc_tx_ready;
      end else if (resetting) begin
         empty_raw = 1'b0;
      end else begin
         empty_raw = (occ == '0);
      end
      empty_next = pol_s ? empty_raw : !empty_raw;
      empty_oe_next = !cs_n_s;
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         tx_fifo_half_flag <= 1'b0;
         tx_fifo_half_flag_oe <= 1'b0;
         tx_fifo_empty_flag <= 1'b0;
         tx_fifo_empty_flag_oe <= 1'b0;
      end else begin
         tx_fifo_half_flag <= half_next;
         tx_fifo_half_flag_oe <= half_oe_next;
         tx_fifo_empty_flag <= empty_next;
         tx_fifo_empty_flag_oe <= empty_oe_next;
      end
   end

   // Receive clock pin and low data port.
   logic rx_host_clock_d_reg;
   logic [7:0] pend_reg;
   logic [7:0] pend_next;
   logic rx_host_clock_out_next;
   logic rx_edge;
   logic [7:0] word_next;
   logic word_oe_next;
   logic rx_output_enable_act;

   always_comb begin
      pend_next = pend_reg;
      if (rx_char_strobe) begin
         if (!dec_on_s) begin
            pend_next = rx_raw_low;
         end else if (!rx_char_is_cmd) begin
            pend_next = rx_decoded_low;
         end
      end
      // The recovered clock is high for one reference period per character.
      rx_host_clock_out_next = rx_char_strobe;
      rx_edge = fifo_on_s ? (rx_host_clock_s && !rx_host_clock_d_reg) : rx_char_strobe;
      rx_output_enable_act = pol_s ? rx_output_enable_s : !rx_output_enable_s;
      word_next = rx_parallel_word;
      word_oe_next = rx_parallel_word_oe;
      if (rx_edge) begin
         word_next = fifo_on_s ? pend_reg : pend_next;
         word_oe_next = rx_output_enable_act;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         // Resetting high matches the idle pin, so no false edge follows reset.
         rx_host_clock_d_reg <= 1'b1;
         pend_reg <= 8'h00;
         rx_host_clock_out <= 1'b0;
         rx_host_clock_oe <= 1'b0;
         rx_parallel_word <= 8'h00;
         rx_parallel_word_oe <= 1'b0;
      end else begin
         rx_host_clock_d_reg <= rx_host_clock_s;
         pend_reg <= pend_next;
         rx_host_clock_out <= rx_host_clock_out_next;
         rx_host_clock_oe <= !fifo_on_s;
         rx_parallel_word <= word_next;
         rx_parallel_word_oe <= word_oe_next;
      end
   end

   AST_HALF_BYPASS_LOW: assert property (@(posedge core_clk) disable iff (!nrst)
      (!fifo_on_s) |=> !tx_fifo_half_flag)
      else $error("Half flag asserted while FIFO bypassed.");
   AST_HALF_LEVEL: assert property (@(posedge core_clk) disable iff (!nrst)
      (fifo_on_s && !resetting && !cs_n_s && occ >= 9'h080) |=> tx_fifo_half_flag)
      else $error("Half flag missing at 128 characters.");
   AST_HALF_IN_RESET: assert property (@(posedge core_clk) disable iff (!nrst)
      (st_reg == hfr_pkg::HFR_FLUSH && fifo_on_s) |=> tx_fifo_half_flag)
      else $error("Half flag not held during FIFO reset.");
   AST_HALF_DRIVEN: assert property (@(posedge core_clk) disable iff (!nrst)
      1'b1 |=> tx_fifo_half_flag_oe)
      else $error("Half flag not driven outside chip reset.");
   AST_EMPTY_IN_RESET: assert property (@(posedge core_clk) disable iff (!nrst)
      (st_reg == hfr_pkg::HFR_FLUSH && fifo_on_s && !bist_s) |=> (tx_fifo_empty_flag == !$past(pol_s)))
      else $error("Empty flag active during FIFO reset.");
   AST_EMPTY_WHEN_NONE: assert property (@(posedge core_clk) disable iff (!nrst)
      (fifo_on_s && !bist_s && !resetting && occ == '0) |=> (tx_fifo_empty_flag == $past(pol_s)))
      else $error("Empty flag not active with an empty FIFO.");
   AST_EMPTY_BYPASS: assert property (@(posedge core_clk) disable iff (!nrst)
      (!fifo_on_s && !bist_s)
      |=> (tx_fifo_empty_flag == ($past(pol_s) ? $past(enc_tx_ready) : !$past(enc_tx_ready))))
      else $error("Empty flag does not follow transmitter readiness in bypass.");
   AST_LOOP_MARK_ONE: assert property (@(posedge core_clk) disable iff (!nrst)
      (bist_s && $past(bist_s) && $changed(seq_reg) && seq_reg == 9'h000 && pol_s && $past(pol_s))
      |-> tx_fifo_empty_flag ##1 !tx_fifo_empty_flag)
      else $error("Loop marker not one period long.");
   AST_EMPTY_OE: assert property (@(posedge core_clk) disable iff (!nrst)
      $past(nrst) |-> (tx_fifo_empty_flag_oe == !$past(cs_n_s)))
      else $error("Empty flag drive does not follow chip select.");
   AST_RX_HOST_CLOCK_DIR: assert property (@(posedge core_clk) disable iff (!nrst)
      (fifo_on_s [*2]) |-> !rx_host_clock_oe)
      else $error("Receive clock driven while host supplies it.");
   AST_RX_CMD_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
      (rx_char_strobe && dec_on_s && rx_char_is_cmd && !fifo_on_s) |=> $stable(rx_parallel_word))
      else $error("Command character disturbed receive data.");
endmodule

// ===== rtl/hfr_cfg.svh
// Constants for the host FIFO flag and receive port block.
`ifndef HFR_CFG_SVH
`define HFR_CFG_SVH
`define HFR_PTR_W 9
`define HFR_HALF_LEVEL 9'h080
`define HFR_RST_CYCLES 3'h7
`define HFR_SEQ_LEN 9'h1ff
`define HFR_SYNC_W 7
`endif

// ===== rtl/hfr_pkg.sv
// Types shared by the host FIFO flag and receive port block.
package hfr_pkg;
   typedef enum logic [1:0] {
      HFR_RUN,
      HFR_FLUSH,
      HFR_SETTLE
   } hfr_fifo_state_t;
endpackage

// ===== rtl/hfr_sync.sv
// Two flip-flop synchroniser for a group of slow levels.
`timescale 1ns/10ps
module hfr_sync #(
   parameter int W = 1
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic nrst,
   // Levels.
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] q_next;

   always_comb begin
      meta_next = d;
      q_next = meta_reg;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= meta_next;
         q <= q_next;
      end
   end
endmodule

// ===== rtl/hfr_txlink.sv
// Host transmit clock side: write pointer and FIFO reset request detection.
`timescale 1ns/10ps
`include "hfr_cfg.svh"
module hfr_txlink #(
   parameter int PTR_W = `HFR_PTR_W
) (
   // Host transmit clock and reset.
   input wire logic tx_host_clock,
   input wire logic nrst,
   // Host controls on the transmit clock.
   input wire logic chip_select_n,
   input wire logic tx_write_req,
   input wire logic tx_fifo_reset_req,
   // Static configuration pin.
   input wire logic fifo_bypass_sel,
   // Towards the flag domain.
   output logic [PTR_W-1:0] wr_ptr_gray,
   output logic fifo_reset_active
);
   logic byp_sync;
   logic cs_n_sync;
   logic [2:0] hold_cnt_reg;
   logic [2:0] hold_cnt_next;
   logic rst_reg;
   logic rst_next;
   logic [PTR_W-1:0] wbin_reg;
   logic [PTR_W-1:0] wbin_next;
   logic [PTR_W-1:0] gray_next;
   logic req_ok;

   // Select and bypass are pins of their own, so both cross before the request logic sees them.
   hfr_sync #(.W(2)) u_byp_sync (
      .clk(tx_host_clock),
      .nrst(nrst),
      .d({chip_select_n, fifo_bypass_sel}),
      .q({cs_n_sync, byp_sync})
   );

   always_comb begin
      req_ok = !tx_fifo_reset_req && !cs_n_sync && !tx_write_req && byp_sync;
      hold_cnt_next = hold_cnt_reg;
      rst_next = rst_reg;
      if (!req_ok) begin
         hold_cnt_next = 3'h0;
      end else if (hold_cnt_reg != `HFR_RST_CYCLES) begin
         hold_cnt_next = hold_cnt_reg + 3'h1;
      end
      // The reset stays in force for as long as the request is held low and the FIFO is not bypassed.
      if (!byp_sync || tx_fifo_reset_req) begin
         rst_next = 1'b0;
      end else if (hold_cnt_next == `HFR_RST_CYCLES) begin
         rst_next = 1'b1;
      end
      wbin_next = wbin_reg;
      if (rst_next) begin
         wbin_next = '0;
      end else if (tx_write_req && !cs_n_sync && byp_sync) begin
         wbin_next = wbin_reg + {{(PTR_W-1){1'b0}}, 1'b1};
      end
      gray_next = wbin_next ^ (wbin_next >> 1);
   end

   always_ff @(posedge tx_host_clock or negedge nrst) begin
      if (!nrst) begin
         hold_cnt_reg <= 3'h0;
         rst_reg <= 1'b0;
         wbin_reg <= '0;
         wr_ptr_gray <= '0;
         fifo_reset_active <= 1'b0;
      end else begin
         hold_cnt_reg <= hold_cnt_next;
         rst_reg <= rst_next;
         wbin_reg <= wbin_next;
         wr_ptr_gray <= gray_next;
         fifo_reset_active <= rst_next;
      end
   end

   AST_RESET_AFTER_SEVEN: assert property (@(posedge tx_host_clock) disable iff (!nrst)
      (req_ok [*7]) |=> fifo_reset_active)
      else $error("FIFO reset not started after seven held request cycles.");
   AST_NO_EARLY_RESET: assert property (@(posedge tx_host_clock) disable iff (!nrst)
      ($rose(fifo_reset_active)) |-> ($past(req_ok, 1) && $past(req_ok, 7)))
      else $error("FIFO reset started before seven request cycles.");
endmodule

// ===== test/hfr_host_model.sv
// Host model driving transmit writes, FIFO reset requests and the receive clock.
`timescale 1ns/10ps
module hfr_host_model (
   // Host transmit clock.
   input wire logic tx_host_clock,
   // Host pins.
   output logic tx_write_req,
   output logic tx_fifo_reset_req,
   output logic host_rx_clk
);
   initial begin
      tx_write_req = 1'b0;
      tx_fifo_reset_req = 1'b1;
      host_rx_clk = 1'b1;
   end
   // Writes come back to back; the host itself keeps below full.
   task automatic write_n(input int n);
      @(posedge tx_host_clock);
      #2 tx_write_req = 1'b1;
      repeat (n) @(posedge tx_host_clock);
      #2 tx_write_req = 1'b0;
   endtask
   // The bench keeps select low and writes idle while the request is held.
   task automatic req_hold(input int n, input logic stay);
      @(posedge tx_host_clock);
      #2 tx_fifo_reset_req = 1'b0;
      repeat (n) @(posedge tx_host_clock);
      #2 tx_fifo_reset_req = stay ? 1'b0 : 1'b1;
   endtask
   task automatic req_release();
      @(posedge tx_host_clock);
      #2 tx_fifo_reset_req = 1'b1;
   endtask
   // Held low long enough for the core synchroniser to see the rising edge.
   task automatic rx_clock_edge();
      host_rx_clk = 1'b0;
      #400 host_rx_clk = 1'b1;
   endtask
endmodule

// ===== test/tb.sv
// Self-checking bench for the transmit flags and the receive port.
`timescale 1ns/10ps
module tb;
   logic core_clk = 1'b0, tx_host_clock = 1'b0, nrst = 1'b0;
   logic chip_select_n = 1'b0, fifo_bypass_sel = 1'b1, flag_polarity_select = 1'b1;
   logic codec_bypass_sel = 1'b1, tx_selftest_enable = 1'b1, rx_output_enable = 1'b1;
   logic enc_char_take = 1'b0, enc_tx_ready = 1'b0, enc_char_tick = 1'b0;
   logic rx_char_strobe = 1'b0, rx_char_is_cmd = 1'b0;
   logic [7:0] rx_decoded_low = 8'h00, rx_raw_low = 8'h00, prev = 8'h00, want;
   wire logic tx_write_req, tx_fifo_reset_req, host_rx_clk, rx_host_clock_in;
   wire logic tx_fifo_half_flag, tx_fifo_half_flag_oe, tx_fifo_empty_flag, tx_fifo_empty_flag_oe;
   wire logic rx_host_clock_out, rx_host_clock_oe, rx_parallel_word_oe;
   wire logic [7:0] rx_parallel_word;
   int failures = 0, tests_run = 0, cycles = 0, n, ones;
   int fill[4] = '{127, 128, 255, 1};
   logic [15:0] lfsr = 16'hcb0d;

   // The pin is driven by the device in bypass and by the host otherwise.
   assign rx_host_clock_in = rx_host_clock_oe ? rx_host_clock_out : host_rx_clk;

   hfr_top u_dut (.core_clk, .nrst, .tx_host_clock, .tx_write_req, .tx_fifo_reset_req, .chip_select_n,
      .fifo_bypass_sel, .flag_polarity_select, .codec_bypass_sel, .tx_selftest_enable, .enc_char_take,
      .enc_tx_ready, .enc_char_tick, .tx_fifo_half_flag, .tx_fifo_half_flag_oe, .tx_fifo_empty_flag,
      .tx_fifo_empty_flag_oe, .rx_char_strobe, .rx_char_is_cmd, .rx_decoded_low, .rx_raw_low,
      .rx_host_clock_in, .rx_host_clock_out, .rx_host_clock_oe, .rx_output_enable, .rx_parallel_word,
      .rx_parallel_word_oe);
   hfr_host_model u_host (.tx_host_clock, .tx_write_req, .tx_fifo_reset_req, .host_rx_clk);

   always #50 core_clk = ~core_clk;
   // The host clock never stops, self-test included, and its rising edges never meet the core rising edges.
   always #16 tx_host_clock = ~tx_host_clock;

   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures = failures + 1;
         stop_test();
      end
   end

   function automatic logic [15:0] next_rand(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   // A command character leaves the decoded word alone; raw mode shows every character.
   function automatic logic [7:0] exp_word(input logic dec_on, cmd, input logic [7:0] dec, raw, old);
      if (!dec_on) return raw;
      return cmd ? old : dec;
   endfunction
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk);
      #5;
   endtask
   task automatic stop_test();
      $display("failures %0d tests_run %0d", failures, tests_run);
      if (failures == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   initial begin
      cyc(5);
      check("half_oe_in_reset", tx_fifo_half_flag_oe, 8'h00);
      cyc(5);
      nrst = 1'b1;
      cyc(4);
      check("half_oe", tx_fifo_half_flag_oe, 8'h01);
      check("empty_oe", tx_fifo_empty_flag_oe, 8'h01);
      check("empty_idle", tx_fifo_empty_flag, 8'h01);
      flag_polarity_select = 1'b0;
      cyc(4);
      check("empty_low_active", tx_fifo_empty_flag, 8'h00);
      flag_polarity_select = 1'b1;
      cyc(4);
      // Fill to either side of the half mark, then drain completely.
      for (int i = 0; i < 5; i++) begin
         lfsr = next_rand(lfsr);
         n = (i < 4) ? fill[i] : int'(lfsr[7:0] | 8'h01);
         u_host.write_n(n);
         cyc(6);
         check("half_fill", tx_fifo_half_flag, 8'(n >= 128));
         check("empty_fill", tx_fifo_empty_flag, 8'h00);
         enc_char_take = 1'b1;
         cyc(n);
         enc_char_take = 1'b0;
         cyc(2);
         check("empty_drain", tx_fifo_empty_flag, 8'h01);
         check("half_drain", tx_fifo_half_flag, 8'h00);
      end
      chip_select_n = 1'b1;
      cyc(4);
      check("empty_oe_deselect", tx_fifo_empty_flag_oe, 8'h00);
      u_host.write_n(200);
      chip_select_n = 1'b0;
      cyc(6);
      check("half_ignored_writes", tx_fifo_half_flag, 8'h00);
      check("empty_oe_select", tx_fifo_empty_flag_oe, 8'h01);
      u_host.write_n(10);
      u_host.req_hold(6, 1'b0);
      cyc(6);
      check("half_short_req", tx_fifo_half_flag, 8'h00);
      check("empty_short_req", tx_fifo_empty_flag, 8'h00);
      u_host.req_hold(7, 1'b1);
      cyc(6);
      check("half_in_flush", tx_fifo_half_flag, 8'h01);
      check("empty_in_flush", tx_fifo_empty_flag, 8'h00);
      u_host.req_release();
      cyc(1);
      check("empty_settling", tx_fifo_empty_flag, 8'h00);
      cyc(8);
      check("half_after_flush", tx_fifo_half_flag, 8'h00);
      check("empty_after_flush", tx_fifo_empty_flag, 8'h01);
      tx_selftest_enable = 1'b0;
      cyc(4);
      ones = 0;
      for (int i = 0; i < 511; i++) begin
         if (i == 510) begin
            check("marker_early", 8'(ones), 8'h00);
            ones = 0;
         end
         enc_char_tick = 1'b1;
         cyc(1);
         enc_char_tick = 1'b0;
         ones += int'(tx_fifo_empty_flag === 1'b1);
         cyc(1);
         ones += int'(tx_fifo_empty_flag === 1'b1);
      end
      repeat (3) begin
         cyc(1);
         ones += int'(tx_fifo_empty_flag === 1'b1);
      end
      check("marker_once", 8'(ones), 8'h01);
      tx_selftest_enable = 1'b1;
      fifo_bypass_sel = 1'b0;
      enc_tx_ready = 1'b1;
      cyc(4);
      u_host.write_n(200);
      cyc(6);
      check("half_bypass", tx_fifo_half_flag, 8'h00);
      check("empty_bypass_ready", tx_fifo_empty_flag, 8'h01);
      check("rx_clk_oe_bypass", rx_host_clock_oe, 8'h01);
      enc_tx_ready = 1'b0;
      cyc(2);
      check("empty_bypass_busy", tx_fifo_empty_flag, 8'h00);
      // Random characters, decoder first and raw mode after, a command forced in early.
      for (int i = 0; i < 12; i++) begin
         lfsr = next_rand(lfsr);
         if (i == 6) codec_bypass_sel = 1'b0;
         rx_output_enable = lfsr[5];
         cyc(4);
         rx_decoded_low = lfsr[7:0];
         rx_raw_low = lfsr[15:8];
         rx_char_is_cmd = lfsr[3] | (i == 2);
         rx_char_strobe = 1'b1;
         want = exp_word(codec_bypass_sel, rx_char_is_cmd, rx_decoded_low, rx_raw_low, prev);
         cyc(1);
         rx_char_strobe = 1'b0;
         check("rx_word", rx_parallel_word, want);
         check("rx_clk_high", rx_host_clock_out, 8'h01);
         check("rx_word_oe", rx_parallel_word_oe, 8'(rx_output_enable));
         cyc(1);
         check("rx_clk_low", rx_host_clock_out, 8'h00);
         prev = want;
      end
      fifo_bypass_sel = 1'b1;
      codec_bypass_sel = 1'b1;
      flag_polarity_select = 1'b0;
      rx_output_enable = 1'b0;
      rx_char_is_cmd = 1'b0;
      // Handing the pin back to the host makes one rising edge of its own; let it pass.
      cyc(8);
      check("rx_clk_oe_fifo", rx_host_clock_oe, 8'h00);
      rx_decoded_low = ~prev;
      rx_char_strobe = 1'b1;
      cyc(1);
      rx_char_strobe = 1'b0;
      cyc(2);
      check("rx_word_waits", rx_parallel_word, prev);
      u_host.rx_clock_edge();
      cyc(4);
      check("rx_word_fifo", rx_parallel_word, ~prev);
      check("rx_word_oe_low_active", rx_parallel_word_oe, 8'h01);
      stop_test();
   end
endmodule
